// *** wwdt_pkg.sv ***
// package: register map, field layout and timing constants of the windowed watchdog
package wwdt_pkg;

   // register indices; byte address is four times the index
   localparam logic [3:0] WWDT_IDX_CTRL = 4'h0;
   localparam logic [3:0] WWDT_IDX_STATUS = 4'h1;
   localparam logic [3:0] WWDT_IDX_CCP = 4'h2;
   localparam int WWDT_ADDR_W = 6;
   localparam logic [WWDT_ADDR_W-1:0] WWDT_ADDR_CTRL = {WWDT_IDX_CTRL, 2'b00};
   localparam logic [WWDT_ADDR_W-1:0] WWDT_ADDR_STATUS = {WWDT_IDX_STATUS, 2'b00};
   localparam logic [WWDT_ADDR_W-1:0] WWDT_ADDR_CCP = {WWDT_IDX_CCP, 2'b00};

   // field positions
   localparam int WWDT_PERIOD_LSB = 0;
   localparam int WWDT_WINDOW_LSB = 4;
   localparam int WWDT_LOCK_BIT = 7;
   localparam int WWDT_BUSY_BIT = 0;

   // reset values
   localparam logic [7:0] WWDT_CTRL_RST = 8'h00;
   localparam logic WWDT_LOCK_RST = 1'b0;

   // period codes
   localparam logic [3:0] WWDT_CODE_OFF = 4'h0;
   localparam logic [3:0] WWDT_CODE_MAX = 4'hb;

   // unlock key; value is arbitrary
   localparam logic [7:0] WWDT_IO_REG_KEY = 8'h5a;
   // bus transfers for which an unlock stays open
   localparam logic [2:0] WWDT_CCP_WINDOW = 3'd4;

   // timing
   localparam int WWDT_SYS_CLK_HZ = 50_000_000;
   localparam int WWDT_OSC_HZ = 1024;
   localparam int WWDT_CNT_W = 14;
   // watchdog clock ticks a clear waits before it takes effect
   localparam logic [1:0] WWDT_CLR_SYNC_TICKS = 2'd2;
   // watchdog clock ticks a control write waits before it takes effect
   localparam logic [1:0] WWDT_CFG_SYNC_TICKS = 2'd2;

   // apb request group
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } wwdt_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } wwdt_apb_rsp_s;

endpackage : wwdt_pkg

// *** wwdt_tick_sync.sv ***
// module: samples the watchdog oscillator pin and makes a one-cycle tick per rising edge
`timescale 1ns/1ns
module wwdt_tick_sync (
   input wire logic ref_clk_i, // system clock
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic osc_clk_i, // watchdog oscillator, asynchronous
   output logic tick_o // one-cycle pulse per oscillator rising edge
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic lvl_r;

   // three-stage sampler; a level counts once stages two and three agree
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         lvl_r <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         s1_r <= osc_clk_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         tick_o <= 1'b0;
         if (s2_r == s3_r) begin
            lvl_r <= s3_r;
            tick_o <= s3_r & ~lvl_r;
         end
      end
   end

endmodule : wwdt_tick_sync

// *** wwdt_core.sv ***
// module: windowed watchdog timer with apb registers, change protection and lock
// clocking and limits
// one system clock; the oscillator pin becomes a tick enable
// three-flop sampling costs up to four system cycles of lag
// the system clock must run far faster than the oscillator
// a stopped system clock also stops the count: accepted trade-off
// all watchdog timing is counted in ticks, not system cycles
//
// bus side
// one wait state on every transfer; answers are registered
// unmapped addresses answer with an error and write nothing; they still use up an unlock slot
// unlocked but refused writes still answer okay, silently
// one protected write consumes the unlock window
//
// watchdog side
// fault is terminal until the system reset arrives
// halt outranks everything but a fault already taken or a period code of off
`timescale 1ns/1ns
module wwdt_core
   import wwdt_pkg::*;
#(
   parameter int CNT_W = WWDT_CNT_W // counter width, must hold 8K ticks
) (
   input wire logic ref_clk_i, // system clock, 50 MHz
   input wire logic rst_n_i, // synchronous reset, active low
   input wire wwdt_apb_req_s apb_i, // apb request group
   output wwdt_apb_rsp_s apb_o, // apb answer group
   input wire logic osc_clk_i, // watchdog oscillator pin
   input wire logic clear_req_i, // watchdog clear instruction pulse
   input wire logic debug_halt_i, // cpu halted by debugger
   input wire logic debug_mode_i, // debugger attached
   input wire logic [7:0] fuse_cfg_i, // watchdog config fuse
   output logic sys_reset_req_o // system reset request, held
);

   // refuse widths that cannot hold the longest period
   initial begin
      if (CNT_W < 14) begin
         $error("wwdt_core: CNT_W must be at least 14");
      end
      if (CNT_W > 31) begin
         $error("wwdt_core: CNT_W must stay below 32");
      end
      // a sync count of zero would wrap to four ticks; an unlock window of zero would never open
      if (WWDT_CLR_SYNC_TICKS == 2'd0) begin
         $error("wwdt_core: clear sync needs at least one tick");
      end
      if (WWDT_CFG_SYNC_TICKS == 2'd0) begin
         $error("wwdt_core: control sync needs at least one tick");
      end
      if (WWDT_CCP_WINDOW == 3'd0) begin
         $error("wwdt_core: unlock window needs at least one transfer");
      end
   end

   typedef enum logic [3:0] {
      WWDT_ST_OFF = 4'b0001,
      WWDT_ST_CLOSED = 4'b0010,
      WWDT_ST_OPEN = 4'b0100,
      WWDT_ST_FAULT = 4'b1000
   } wwdt_state_e;

   // length in ticks of a period code; reserved codes run as the longest
   // code one gives eight ticks, each further step doubles
   function automatic logic [CNT_W-1:0] len_f(input logic [3:0] code);
      logic [3:0] c;
      c = (code > WWDT_CODE_MAX) ? WWDT_CODE_MAX : code;
      len_f = CNT_W'(1) << (c + 4'd2);
   endfunction : len_f

   // register state
   logic tick;
   logic [7:0] ctrl_r; // software view of control
   logic [7:0] eff_r; // control as seen by the counter
   logic lock_r;
   logic busy_r; // sync pending flag
   logic [1:0] cfg_cnt_r;
   logic clr_busy_r;
   logic [1:0] clr_cnt_r;
   logic clr_apply_r;
   logic [2:0] unlock_r;
   logic boot_r;
   logic halt_q_r;
   logic [CNT_W-1:0] cnt_r;
   wwdt_state_e state_r;
   // combinational decode
   logic xfer;
   logic wr;
   logic [WWDT_ADDR_W-1:0] addr;
   logic mapped;
   logic unlocked;
   logic [3:0] eff_per;
   logic [3:0] eff_win;
   logic [CNT_W-1:0] limit;
   logic ctrl_wr; // accepted protected control write
   logic stat_wr; // accepted protected status write

   // oscillator pin to one-cycle tick enable
   wwdt_tick_sync u_tick (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .osc_clk_i(osc_clk_i),
      .tick_o(tick)
   );

   // bus decode; a transfer completes on the edge where pready is high
   assign xfer = apb_i.psel & apb_i.penable & apb_o.pready;
   assign wr = xfer & apb_i.pwrite & ~apb_o.pslverr;
   assign addr = apb_i.paddr[WWDT_ADDR_W-1:0];
   assign mapped = (apb_i.paddr[31:WWDT_ADDR_W] == '0) &&
      ((addr == WWDT_ADDR_CTRL) || (addr == WWDT_ADDR_STATUS) || (addr == WWDT_ADDR_CCP));
   assign unlocked = (unlock_r != 3'd0);
   assign eff_per = eff_r[WWDT_PERIOD_LSB +: 4];
   assign eff_win = eff_r[WWDT_WINDOW_LSB +: 4];
   // protected writes that may land; the lock guards control only
   assign ctrl_wr = wr & unlocked & (addr == WWDT_ADDR_CTRL) & ~lock_r;
   assign stat_wr = wr & unlocked & (addr == WWDT_ADDR_STATUS);

   // apb answer: one wait state, data and error registered with pready
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         apb_o <= '0;
      end else begin
         // answer exactly one cycle after the access phase opens
         apb_o.pready <= apb_i.psel & apb_i.penable & ~apb_o.pready;
         apb_o.pslverr <= apb_i.psel & apb_i.penable & ~apb_o.pready & ~mapped;
         apb_o.prdata <= 32'h0000_0000;
         // data only in the answer cycle; error answers stay zero unless the low six address bits hit a register
         if (apb_i.psel & apb_i.penable & ~apb_o.pready & ~apb_i.pwrite) begin
            case (addr)
               WWDT_ADDR_CTRL: apb_o.prdata <= {24'h00_0000, ctrl_r};
               WWDT_ADDR_STATUS: begin
                  apb_o.prdata[WWDT_LOCK_BIT] <= lock_r;
                  apb_o.prdata[WWDT_BUSY_BIT] <= busy_r;
               end
               default: apb_o.prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // unlock window: key write opens it, each later transfer uses one slot
   // a key write in the last slot reopens the window: set wins
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         unlock_r <= 3'd0;
      end else if (wr && addr == WWDT_ADDR_CCP && apb_i.pwdata[7:0] == WWDT_IO_REG_KEY) begin
         unlock_r <= WWDT_CCP_WINDOW;
      end else if (wr && (addr == WWDT_ADDR_CTRL || addr == WWDT_ADDR_STATUS)) begin
         unlock_r <= 3'd0; // one protected write per unlock
      end else if (xfer && unlocked) begin
         unlock_r <= unlock_r - 3'd1;
      end
   end

   // boot marker: fuse is caught on the first edge after reset release
   // the fuse is a level from boot logic, steady by reset release
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         boot_r <= 1'b1;
      end else begin
         boot_r <= 1'b0;
      end
   end

   // control register and lock; writes need unlock and a clear lock
   // the lock bit itself stays key protected but is never self-locked
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ctrl_r <= WWDT_CTRL_RST;
         lock_r <= WWDT_LOCK_RST;
      end else if (boot_r) begin
         ctrl_r <= fuse_cfg_i;
         lock_r <= (fuse_cfg_i[WWDT_PERIOD_LSB +: 4] != WWDT_CODE_OFF);
      end else begin
         // a write without a live unlock never gets through here
         if (ctrl_wr) begin
            ctrl_r <= apb_i.pwdata[7:0];
         end
         if (stat_wr) begin
            if (apb_i.pwdata[WWDT_LOCK_BIT]) begin
               lock_r <= 1'b1;
            end else if (debug_mode_i) begin
               lock_r <= 1'b0;
            end
         end
      end
   end

   // control sync: busy until two oscillator ticks have passed
   // a write while busy restarts the count; software must not do that
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         eff_r <= WWDT_CTRL_RST;
         busy_r <= 1'b0;
         cfg_cnt_r <= 2'd0;
      end else if (boot_r) begin
         eff_r <= fuse_cfg_i;
      end else if (ctrl_wr) begin
         busy_r <= 1'b1;
         cfg_cnt_r <= 2'd0;
      end else if (busy_r && tick) begin
         if (cfg_cnt_r == WWDT_CFG_SYNC_TICKS - 2'd1) begin
            eff_r <= ctrl_r;
            busy_r <= 1'b0;
         end else begin
            cfg_cnt_r <= cfg_cnt_r + 2'd1;
         end
      end
   end

   // clear sync: a clear is taken into the watchdog clock over two ticks
   // with tick phase unknown this spans one to two oscillator periods
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         clr_busy_r <= 1'b0;
         clr_cnt_r <= 2'd0;
         clr_apply_r <= 1'b0;
      end else begin
         clr_apply_r <= 1'b0;
         if (clear_req_i && !clr_busy_r) begin
            clr_busy_r <= 1'b1; // later clears ignored while set
            clr_cnt_r <= 2'd0;
         end else if (clr_busy_r && tick) begin
            if (clr_cnt_r == WWDT_CLR_SYNC_TICKS - 2'd1) begin
               clr_busy_r <= 1'b0;
               clr_apply_r <= 1'b1;
            end else begin
               clr_cnt_r <= clr_cnt_r + 2'd1;
            end
         end
      end
   end

   // current limit: closed length in the closed period, else open length
   // a code change takes effect at the next comparison, never mid-tick
   assign limit = (state_r == WWDT_ST_CLOSED) ? len_f(eff_win) : len_f(eff_per);

   // debug halt edge memory for resume handling
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         halt_q_r <= 1'b0;
      end else begin
         halt_q_r <= debug_halt_i;
      end
   end

   // watchdog state and counter; counting only on oscillator ticks
   // fault is terminal: only a system reset leaves it
   // halt outranks counting so a halted cpu is never reset
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_r <= WWDT_ST_OFF;
         cnt_r <= '0;
      end else if (state_r == WWDT_ST_FAULT) begin
         state_r <= WWDT_ST_FAULT; // held until system reset
      end else if (eff_per == WWDT_CODE_OFF) begin
         state_r <= WWDT_ST_OFF;
         cnt_r <= '0;
      end else if (debug_halt_i) begin
         state_r <= WWDT_ST_OPEN; // resume runs a normal time-out
         cnt_r <= '0;
      end else if (halt_q_r) begin
         // first cycle after the halt: restart the open time-out cleanly
         state_r <= WWDT_ST_OPEN;
         cnt_r <= '0;
      end else begin
         case (state_r)
            WWDT_ST_OFF: begin
               state_r <= WWDT_ST_OPEN; // window waits for first clear
               cnt_r <= '0;
            end
            WWDT_ST_OPEN: begin
               if (clr_apply_r) begin
                  cnt_r <= '0;
                  state_r <= (eff_win != WWDT_CODE_OFF) ? WWDT_ST_CLOSED : WWDT_ST_OPEN;
               end else if (tick) begin
                  if (cnt_r == limit - CNT_W'(1)) begin
                     state_r <= WWDT_ST_FAULT;
                  end else begin
                     cnt_r <= cnt_r + CNT_W'(1);
                  end
               end
            end
            WWDT_ST_CLOSED: begin
               if (clr_apply_r) begin
                  state_r <= WWDT_ST_FAULT;
               end else if (eff_win == WWDT_CODE_OFF) begin
                  state_r <= WWDT_ST_OPEN;
                  cnt_r <= '0;
               end else if (tick) begin
                  if (cnt_r == limit - CNT_W'(1)) begin
                     state_r <= WWDT_ST_OPEN;
                     cnt_r <= '0;
                  end else begin
                     cnt_r <= cnt_r + CNT_W'(1);
                  end
               end
            end
            default: begin
               state_r <= WWDT_ST_OFF;
               cnt_r <= '0;
            end
         endcase
      end
   end

   // reset request output, held until the system reset arrives
   // one cycle behind the fault state so the output comes from a flop
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sys_reset_req_o <= 1'b0;
      end else if (state_r == WWDT_ST_FAULT) begin
         sys_reset_req_o <= 1'b1;
      end
   end

endmodule : wwdt_core

// *** wwdt_cpu_model.sv ***
// cpu side model: watchdog oscillator and clear pulses
`timescale 1ns/1ns
module wwdt_cpu_model (
   input wire logic clk_i, // system clock
   output logic osc_o, // oscillator stand-in
   output logic clr_o // clear instruction pulse
);
   // oscillator sped up so time-outs stay short; odd half period drifts in phase
   initial osc_o = 1'b0;
   always #83 osc_o = ~osc_o;
   initial clr_o = 1'b0;

   // one-cycle clear pulse launched right after an edge
   task clear();
      @(posedge clk_i);
      clr_o <= 1'b1;
      @(posedge clk_i);
      clr_o <= 1'b0;
   endtask : clear
endmodule : wwdt_cpu_model

// *** wwdt_core_properties.sv ***
// port checker of the watchdog core and its bind
`timescale 1ns/1ns
module wwdt_core_properties
   import wwdt_pkg::*;
(
   input wire logic ref_clk_i, // system clock
   input wire logic rst_n_i, // reset, active low
   input wire wwdt_apb_req_s apb_i, // apb request
   input wire wwdt_apb_rsp_s apb_o, // apb answer
   input wire logic debug_halt_i, // debugger halt
   input wire logic sys_reset_req_o // reset request
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   // completed transfer and address decode
   logic done;
   logic bad_a;
   assign done = apb_i.psel && apb_i.penable && apb_o.pready;
   assign bad_a = !(apb_i.paddr inside {WWDT_ADDR_CTRL, WWDT_ADDR_STATUS, WWDT_ADDR_CCP});

   sequence s_one_wait;
      !apb_o.pready ##1 apb_o.pready;
   endsequence

   a_one_wait: assert property (apb_i.psel && $rose(apb_i.penable) |-> s_one_wait)
      else $error("pready not after one wait state");
   a_pready_pulse: assert property (apb_o.pready |=> !apb_o.pready)
      else $error("pready longer than one cycle");
   a_no_req_quiet: assert property (!apb_i.psel |=> !apb_o.pready)
      else $error("pready without request");
   a_slverr_map: assert property (done |-> apb_o.pslverr == bad_a)
      else $error("pslverr does not match address map");
   a_err_data_zero: assert property (done && apb_o.pslverr |-> apb_o.prdata == 32'h0)
      else $error("error answer carries data");
   a_upper_zero: assert property (done |-> apb_o.prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_req_held: assert property (sys_reset_req_o |=> sys_reset_req_o)
      else $error("reset request dropped");
   a_quiet_boot: assert property ($rose(rst_n_i) |-> !sys_reset_req_o)
      else $error("reset request right after reset");
   a_halt_no_fault: assert property (debug_halt_i [*3] |=> !$rose(sys_reset_req_o))
      else $error("fault while halted");
endmodule : wwdt_core_properties

bind wwdt_core wwdt_core_properties u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i),
   .apb_o(apb_o), .debug_halt_i(debug_halt_i), .sys_reset_req_o(sys_reset_req_o));

// *** test_windowed_watchdog_timer.sv ***
// self-checking bench of the windowed watchdog
`timescale 1ns/1ns
module test_windowed_watchdog_timer;
   import wwdt_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic halt = 1'b0;
   logic dbg = 1'b0;
   logic osc;
   logic clr;
   logic rreq;
   logic er;
   logic [7:0] fuse = 8'h00;
   logic [31:0] rd;
   wwdt_apb_req_s req = '0;
   wwdt_apb_rsp_s rsp;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;

   always #10 ref_clk_i = ~ref_clk_i;

   wwdt_cpu_model u_cpu (.clk_i(ref_clk_i), .osc_o(osc), .clr_o(clr));
   wwdt_core DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp), .osc_clk_i(osc),
      .clear_req_i(clr), .debug_halt_i(halt), .debug_mode_i(dbg), .fuse_cfg_i(fuse), .sys_reset_req_o(rreq));

   task close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   // hang guard, generous against the expected run of some 1000 cycles
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 8000) begin
         num_errors++;
         $display("[FAIL] %0t timeout", $time);
         close_out();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen at an edge
   task xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {26'h0, a}, pwdata: {24'h0, d}};
      @(posedge ref_clk_i);
      req.penable <= 1'b1;
      // without pready only the hang guard ends this wait
      do begin
         @(posedge ref_clk_i);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer

   // key then protected write
   task pw(input logic [5:0] a, input logic [7:0] d);
      xfer(1'b1, WWDT_ADDR_CCP, WWDT_IO_REG_KEY);
      xfer(1'b1, a, d);
   endtask : pw

   // poll until the control value has crossed over
   task idle();
      int n;
      n = 0;
      do begin
         xfer(1'b0, WWDT_ADDR_STATUS, 8'h00);
         n++;
      end while (rd[0] !== 1'b0 && n < 20);
      chk(rd[0], 0, "busy stuck");
   endtask : idle

   task rst(input logic [7:0] f);
      @(posedge ref_clk_i);
      fuse <= f;
      rst_n_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
   endtask : rst

   // no reset request for n cycles
   task quiet(input int n);
      logic s;
      s = 1'b0;
      repeat (n) begin
         @(posedge ref_clk_i);
         s = s | rreq;
      end
      chk(s, 0, "early reset");
   endtask : quiet

   // reset request must rise between lo and hi cycles from now
   task exp_rst(input int lo, input int hi);
      int n;
      n = 0;
      while (rreq !== 1'b1 && n <= hi) begin
         @(posedge ref_clk_i);
         n++;
      end
      chk(n >= lo && n <= hi, 1, "reset timing");
   endtask : exp_rst

   initial begin
      rst(8'h00);
      xfer(1'b0, WWDT_ADDR_CTRL, 8'h00);
      chk(rd, 0, "ctrl reset");
      xfer(1'b0, WWDT_ADDR_STATUS, 8'h00);
      chk(rd, 0, "status reset");
      xfer(1'b0, 6'h0c, 8'h00);
      chk(er, 1, "unmapped");
      xfer(1'b1, WWDT_ADDR_CTRL, 8'h01);
      xfer(1'b0, WWDT_ADDR_CTRL, 8'h00);
      chk(rd, 0, "write without key");
      pw(WWDT_ADDR_CTRL, 8'h01);
      xfer(1'b0, WWDT_ADDR_STATUS, 8'h00);
      chk(rd[0], 1, "busy after write");
      idle();
      xfer(1'b0, WWDT_ADDR_CTRL, 8'h00);
      chk(rd, 8'h01, "ctrl keyed write");
      // normal mode, 8 ticks of 8.3 cycles, clears keep it alive
      repeat (4) begin
         u_cpu.clear();
         quiet(40);
      end
      exp_rst(28, 60);
      repeat (30) @(posedge ref_clk_i);
      chk(rreq, 1, "request held");
      // boot from fuse: 16 ticks, locked
      rst(8'h02);
      xfer(1'b0, WWDT_ADDR_STATUS, 8'h00);
      chk(rd[7], 1, "fuse lock");
      pw(WWDT_ADDR_CTRL, 8'h00);
      xfer(1'b0, WWDT_ADDR_CTRL, 8'h00);
      chk(rd, 8'h02, "locked ctrl");
      pw(WWDT_ADDR_STATUS, 8'h00);
      xfer(1'b0, WWDT_ADDR_STATUS, 8'h00);
      chk(rd[7], 1, "lock kept");
      u_cpu.clear();
      dbg <= 1'b1;
      pw(WWDT_ADDR_STATUS, 8'h00);
      xfer(1'b0, WWDT_ADDR_STATUS, 8'h00);
      chk(rd[7], 0, "lock cleared in debug");
      dbg <= 1'b0;
      // key expires after four transfers
      xfer(1'b1, WWDT_ADDR_CCP, WWDT_IO_REG_KEY);
      repeat (4) xfer(1'b0, WWDT_ADDR_CTRL, 8'h00);
      xfer(1'b1, WWDT_ADDR_CTRL, 8'h00);
      xfer(1'b0, WWDT_ADDR_CTRL, 8'h00);
      chk(rd, 8'h02, "stale key");
      halt <= 1'b1;
      quiet(300);
      halt <= 1'b0;
      exp_rst(100, 160);
      // window mode, closed and open both 8 ticks
      rst(8'h00);
      pw(WWDT_ADDR_CTRL, 8'h11);
      idle();
      u_cpu.clear();
      repeat (3) @(posedge ref_clk_i);
      u_cpu.clear();
      quiet(90);
      u_cpu.clear();
      quiet(30);
      u_cpu.clear();
      exp_rst(5, 40);
      close_out();
   end
endmodule : test_windowed_watchdog_timer
